// File: verilog/ioxr_pkg.sv
// ****************************************************************
// Shared types and constants for the I/O exerciser
// ****************************************************************
package ioxr_pkg;

  // ****************************************************************
  // Packet field widths
  // ****************************************************************
  localparam int TID_W  = 8;   // Transaction id width
  localparam int PRIO_W = 2;   // Priority field width
  localparam int ADDR_W = 32;  // Byte address width
  localparam int DATA_W = 64;  // One beat of payload

  // Transaction kinds carried in each beat
  typedef enum logic [2:0] {
    KIND_NREAD     = 3'h0,  // Read, answered with data
    KIND_NWRITE    = 3'h1,  // Write, no answer
    KIND_NWRITE_R  = 3'h2,  // Write, answered without data
    KIND_SWRITE    = 3'h3,  // Streaming write, never answered
    KIND_DOORBELL  = 3'h4,  // Doorbell, answered without data
    KIND_RESP_NODT = 3'h5,  // Response carrying no data
    KIND_RESP_DATA = 3'h6   // Response carrying data
  } ioxr_kind_t;

  // One single-beat packet on any of the stream ports
  typedef struct packed {
    ioxr_kind_t          kind;  // Transaction kind
    logic [TID_W-1:0]    tid;   // Transaction id
    logic [PRIO_W-1:0]   prio;  // Priority
    logic [ADDR_W-1:0]   addr;  // Byte address
    logic [DATA_W-1:0]   data;  // Payload
  } ioxr_pkt_t;

  // ****************************************************************
  // Scratch region and script layout
  // ****************************************************************
  localparam logic [15:0] SCRATCH_TAG    = 16'h0012;  // Upper address half of scratch space
  localparam int          SCRATCH_HI     = 31;        // Top bit of the region tag
  localparam int          SCRATCH_LO     = 16;        // Bottom bit of the region tag
  localparam int          WORD_LSB       = 3;         // Byte-in-word bits below the word index
  localparam int          SCRIPT_LEN     = 8;         // Entries in the transaction script
  localparam int          SLOT_W         = 3;         // Expected-response slots indexed by tid low bits
  localparam logic [4:0]  ALL_REQ_KINDS  = 5'h1f;     // One enable bit per request kind
  localparam logic [7:0]  PATTERN_STEP   = 8'h01;     // Byte increment of the fill pattern
  localparam logic [PRIO_W-1:0] PRIO_STEP = 2'h1;     // Answer priority above request priority

endpackage : ioxr_pkg

// File: verilog/ioxr_scratch_mem.sv
`timescale 1ns/10ps
// ****************************************************************
// Scratch memory: one write port, registered read port
// ****************************************************************
module ioxr_scratch_mem #(
  parameter int AW = 6,   // Word address width
  parameter int DW = 64   // Word width
) (
  // Clock
  input  wire logic          clk,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // Read port, data one cycle after the strobe
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);

  // Storage array, no reset so it maps onto block memory
  logic [DW-1:0] mem_array [0:(1<<AW)-1];

  // Write then registered read
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_array[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem_array[rd_addr];
    end
  end

endmodule : ioxr_scratch_mem

// File: verilog/ioxr_top.sv
`timescale 1ns/10ps
// Function
// - Issue only parameter-permitted transaction kinds
// - Record expected responses, flag mismatches
// - Replay script in fixed order
// - Compare responses only under automatic stimulus
// - Parameter zero bypasses to external streams
// - Store scratch-region write payloads locally
// - Drop other no-response writes silently
// - Never answer streaming writes
// - Scratch reads return stored memory data
// - Other reads get incrementing fill pattern
// - Answer requests strictly in arrival order
// - Answer priority is request priority plus one
// - Answer only response-generating request kinds
module ioxr_top
  import ioxr_pkg::*;
#(
  parameter bit         AUTO_IO_STIMULUS_PARAM = 1'b1,           // One: internal stimulus
  parameter logic [4:0] ALLOWED_KINDS          = ioxr_pkg::ALL_REQ_KINDS,  // Bit per ioxr_kind_t
  parameter int         MEM_AW                 = 6              // Scratch words, log2
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // Initiator request toward the core
  output logic                     ireq_tvalid,
  input  wire logic                ireq_tready,
  output ioxr_pkg::ioxr_pkt_t      ireq_tdata,
  // Initiator response from the core
  input  wire logic                iresp_tvalid,
  output logic                     iresp_tready,
  input  wire ioxr_pkg::ioxr_pkt_t iresp_tdata,
  // Target request from the core
  input  wire logic                treq_tvalid,
  output logic                     treq_tready,
  input  wire ioxr_pkg::ioxr_pkt_t treq_tdata,
  // Target response toward the core
  output logic                     tresp_tvalid,
  input  wire logic                tresp_tready,
  output ioxr_pkg::ioxr_pkt_t      tresp_tdata,
  // External user initiator streams
  input  wire logic                usr_ireq_tvalid,
  output logic                     usr_ireq_tready,
  input  wire ioxr_pkg::ioxr_pkt_t usr_ireq_tdata,
  output logic                     usr_iresp_tvalid,
  input  wire logic                usr_iresp_tready,
  output ioxr_pkg::ioxr_pkt_t      usr_iresp_tdata,
  // External user target streams
  output logic                     usr_treq_tvalid,
  input  wire logic                usr_treq_tready,
  output ioxr_pkg::ioxr_pkt_t      usr_treq_tdata,
  input  wire logic                usr_tresp_tvalid,
  output logic                     usr_tresp_tready,
  input  wire ioxr_pkg::ioxr_pkt_t usr_tresp_tdata,
  // Exerciser status
  output logic                     exercise_done,
  output logic                     mismatch_seen
);
  import ioxr_pkg::*;

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  // Kinds whose requests call for an answer
  function automatic logic wants_resp(input ioxr_kind_t k);
    wants_resp = (k == KIND_NREAD) || (k == KIND_NWRITE_R) || (k == KIND_DOORBELL);
  endfunction : wants_resp

  // Answer kind expected for a request kind
  function automatic ioxr_kind_t resp_kind(input ioxr_kind_t k);
    resp_kind = (k == KIND_NREAD) ? KIND_RESP_DATA : KIND_RESP_NODT;
  endfunction : resp_kind

  // Address inside the scratch region
  function automatic logic in_scratch(input logic [ADDR_W-1:0] a);
    in_scratch = (a[SCRATCH_HI:SCRATCH_LO] == SCRATCH_TAG);
  endfunction : in_scratch

  // Fixed script; contents look random but the order never changes
  function automatic ioxr_pkt_t script_entry(input logic [3:0] i);
    ioxr_pkt_t p;
    p = '0;
    case (i)
      4'h0:    p = '{KIND_NWRITE_R, 8'h10, 2'h0, 32'h0012_0040, 64'h3c5a_91e2_07bd_4f18};
      4'h1:    p = '{KIND_NREAD,    8'h11, 2'h1, 32'h0012_0040, 64'h0000_0000_0000_0000};
      4'h2:    p = '{KIND_SWRITE,   8'h12, 2'h0, 32'h0012_0088, 64'h9e41_c270_55ab_13d6};
      4'h3:    p = '{KIND_NREAD,    8'h13, 2'h2, 32'h0047_1a30, 64'h0000_0000_0000_0000};
      4'h4:    p = '{KIND_DOORBELL, 8'h14, 2'h1, 32'h0000_0000, 64'h0000_0000_0000_a5c3};
      4'h5:    p = '{KIND_NWRITE,   8'h15, 2'h0, 32'h0033_0c08, 64'h61f0_2b9d_e8c4_7a35};
      4'h6:    p = '{KIND_NREAD,    8'h16, 2'h0, 32'h0012_0088, 64'h0000_0000_0000_0000};
      4'h7:    p = '{KIND_NWRITE_R, 8'h17, 2'h2, 32'h005e_2210, 64'h0d83_f6a9_4e12_b07c};
      default: p = '0;
    endcase
    script_entry = p;
  endfunction : script_entry

  // Byte-wise incrementing fill starting at base
  function automatic logic [DATA_W-1:0] fill_pattern(input logic [7:0] base);
    logic [DATA_W-1:0] d;
    d = '0;
    for (int b = 0; b < DATA_W/8; b++) begin
      d[b*8 +: 8] = base + 8'(b) * PATTERN_STEP;
    end
    fill_pattern = d;
  endfunction : fill_pattern

  // ****************************************************************
  // Request generator
  // ****************************************************************
  typedef enum logic [1:0] {
    RQ_LOAD = 2'b00,  // Fetch next script entry
    RQ_SEND = 2'b01,  // Offer request to the core
    RQ_DONE = 2'b10   // Script exhausted
  } ioxr_rq_state_t;

  ioxr_rq_state_t             rq_state_reg;   // Request sequencer state
  logic [3:0]                 idx_reg;        // Script position
  ioxr_pkt_t                  req_pkt_reg;    // Request on offer
  logic [(1<<SLOT_W)-1:0]     pend_reg;       // Answer outstanding per slot
  ioxr_kind_t                 exp_kind_reg [0:(1<<SLOT_W)-1];  // Expected answer kind per slot
  logic                       mismatch_reg;   // Sticky mismatch flag

  // Current script entry and its decode
  ioxr_pkt_t   cur_entry;
  wire         cur_allowed   = ALLOWED_KINDS[cur_entry.kind];
  wire [SLOT_W-1:0] cur_slot = cur_entry.tid[SLOT_W-1:0];
  wire [SLOT_W-1:0] snd_slot = req_pkt_reg.tid[SLOT_W-1:0];
  wire [SLOT_W-1:0] rsp_slot = iresp_tdata.tid[SLOT_W-1:0];
  wire         script_end    = (idx_reg == 4'(SCRIPT_LEN));
  wire         a_ireq_valid  = (rq_state_reg == RQ_SEND);
  wire         a_ireq_fire   = a_ireq_valid && ireq_tready;
  wire         a_iresp_fire  = AUTO_IO_STIMULUS_PARAM && iresp_tvalid;  // Always ready in auto mode
  wire         set_pend      = a_ireq_fire && wants_resp(req_pkt_reg.kind);
  wire         rsp_bad       = !pend_reg[rsp_slot] || (iresp_tdata.kind != exp_kind_reg[rsp_slot]);

  assign cur_entry = script_entry(idx_reg);

  // Sequencer: skip forbidden kinds, stall while the tid slot is busy
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rq_state_reg <= RQ_LOAD;
      idx_reg      <= '0;
      req_pkt_reg  <= '0;
    end else if (AUTO_IO_STIMULUS_PARAM) begin
      case (rq_state_reg)
        RQ_LOAD: begin
          if (script_end) begin
            rq_state_reg <= RQ_DONE;
          end else if (!cur_allowed) begin
            idx_reg <= idx_reg + 4'h1;
          end else if (!pend_reg[cur_slot]) begin
            req_pkt_reg  <= cur_entry;
            rq_state_reg <= RQ_SEND;
          end
        end
        RQ_SEND: begin
          if (a_ireq_fire) begin
            idx_reg      <= idx_reg + 4'h1;
            rq_state_reg <= RQ_LOAD;
          end
        end
        RQ_DONE: rq_state_reg <= RQ_DONE;
        default: rq_state_reg <= RQ_LOAD;
      endcase
    end
  end

  // Expected-answer book: the set is applied after the clear, so it wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pend_reg     <= '0;
      mismatch_reg <= 1'b0;
      for (int s = 0; s < (1<<SLOT_W); s++) begin
        exp_kind_reg[s] <= KIND_RESP_NODT;
      end
    end else begin
      if (a_iresp_fire) begin
        pend_reg[rsp_slot] <= 1'b0;
        if (rsp_bad) begin
          mismatch_reg <= 1'b1;
        end
      end
      if (set_pend) begin
        pend_reg[snd_slot]     <= 1'b1;
        exp_kind_reg[snd_slot] <= resp_kind(req_pkt_reg.kind);
      end
    end
  end

  // ****************************************************************
  // Response generator
  // ****************************************************************
  typedef enum logic [1:0] {
    RS_IDLE = 2'b00,  // Ready for the next request
    RS_READ = 2'b01,  // Memory read in flight
    RS_SEND = 2'b10   // Answer on offer
  } ioxr_rs_state_t;

  ioxr_rs_state_t    rs_state_reg;  // Responder state
  ioxr_pkt_t         rsp_pkt_reg;   // Answer being built or offered
  logic [7:0]        pat_base_reg;  // Fill pattern start, moves per use
  logic [DATA_W-1:0] mem_rd_data;   // Scratch read data

  // One request at a time keeps answers in arrival order
  wire a_treq_ready = (rs_state_reg == RS_IDLE);
  wire a_treq_fire  = AUTO_IO_STIMULUS_PARAM && treq_tvalid && a_treq_ready;
  wire rq_scratch   = in_scratch(treq_tdata.addr);
  wire rq_is_write  = (treq_tdata.kind == KIND_NWRITE) || (treq_tdata.kind == KIND_NWRITE_R) ||
                      (treq_tdata.kind == KIND_SWRITE);
  wire rq_answer    = wants_resp(treq_tdata.kind);
  wire rq_mem_read  = (treq_tdata.kind == KIND_NREAD) && rq_scratch;
  wire mem_wr_en    = a_treq_fire && rq_is_write && rq_scratch;
  wire mem_rd_en    = a_treq_fire && rq_mem_read;
  wire a_tresp_fire = (rs_state_reg == RS_SEND) && tresp_tready;
  wire [MEM_AW-1:0] mem_idx = treq_tdata.addr[WORD_LSB +: MEM_AW];

  // Scratch store
  ioxr_scratch_mem #(
    .AW (MEM_AW),
    .DW (DATA_W)
  ) u_scratch (
    .clk     (clk),
    .wr_en   (mem_wr_en),
    .wr_addr (mem_idx),
    .wr_data (treq_tdata.data),
    .rd_en   (mem_rd_en),
    .rd_addr (mem_idx),
    .rd_data (mem_rd_data)
  );

  // Responder: build header on accept, fill data now or after the read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rs_state_reg <= RS_IDLE;
      rsp_pkt_reg  <= '0;
      pat_base_reg <= '0;
    end else begin
      case (rs_state_reg)
        RS_IDLE: begin
          if (a_treq_fire && rq_answer) begin
            rsp_pkt_reg.kind <= resp_kind(treq_tdata.kind);
            rsp_pkt_reg.tid  <= treq_tdata.tid;
            rsp_pkt_reg.prio <= treq_tdata.prio + PRIO_STEP;
            rsp_pkt_reg.addr <= treq_tdata.addr;
            if (rq_mem_read) begin
              rs_state_reg <= RS_READ;
            end else begin
              // Data-free answers still carry the pattern and advance its base, like fill reads
              rsp_pkt_reg.data <= fill_pattern(pat_base_reg);
              pat_base_reg     <= pat_base_reg + PATTERN_STEP;
              rs_state_reg     <= RS_SEND;
            end
          end
        end
        RS_READ: begin
          rsp_pkt_reg.data <= mem_rd_data;
          rs_state_reg     <= RS_SEND;
        end
        RS_SEND: begin
          if (a_tresp_fire) begin
            rs_state_reg <= RS_IDLE;
          end
        end
        default: rs_state_reg <= RS_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Port selection between exerciser and external streams
  // ****************************************************************
  // Bypass is a pure wire path, so external users see the core unchanged
  assign ireq_tvalid      = AUTO_IO_STIMULUS_PARAM ? a_ireq_valid : usr_ireq_tvalid;
  assign ireq_tdata       = AUTO_IO_STIMULUS_PARAM ? req_pkt_reg  : usr_ireq_tdata;
  assign usr_ireq_tready  = AUTO_IO_STIMULUS_PARAM ? 1'b0 : ireq_tready;
  assign iresp_tready     = AUTO_IO_STIMULUS_PARAM ? 1'b1 : usr_iresp_tready;
  assign usr_iresp_tvalid = AUTO_IO_STIMULUS_PARAM ? 1'b0 : iresp_tvalid;
  assign usr_iresp_tdata  = iresp_tdata;
  assign treq_tready      = AUTO_IO_STIMULUS_PARAM ? a_treq_ready : usr_treq_tready;
  assign usr_treq_tvalid  = AUTO_IO_STIMULUS_PARAM ? 1'b0 : treq_tvalid;
  assign usr_treq_tdata   = treq_tdata;
  assign tresp_tvalid     = AUTO_IO_STIMULUS_PARAM ? (rs_state_reg == RS_SEND) : usr_tresp_tvalid;
  assign tresp_tdata      = AUTO_IO_STIMULUS_PARAM ? rsp_pkt_reg : usr_tresp_tdata;
  assign usr_tresp_tready = AUTO_IO_STIMULUS_PARAM ? 1'b0 : tresp_tready;

  // Status: done once the script is spent and every answer is back
  assign exercise_done = AUTO_IO_STIMULUS_PARAM && (rq_state_reg == RQ_DONE) && (pend_reg == '0);
  assign mismatch_seen = mismatch_reg;

endmodule : ioxr_top

// File: bench/ioxr_core_model.sv
`timescale 1ns/10ps
// ****************************************************************
// Far-side model: endpoint logical layer, initiator half
// ****************************************************************
module ioxr_core_model
  import ioxr_pkg::*;
(
  // Clock, reset and mode
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                slow,
  input  wire logic                bad,
  // Request from the exerciser
  input  wire logic                ireq_tvalid,
  output logic                     ireq_tready,
  input  wire ioxr_pkg::ioxr_pkt_t ireq_tdata,
  // Response to the exerciser
  output logic                     iresp_tvalid,
  input  wire logic                iresp_tready,
  output ioxr_pkg::ioxr_pkt_t      iresp_tdata
);
  ioxr_pkt_t  q[$];  // Answers waiting to go out
  ioxr_pkt_t  p;     // Answer under construction
  logic [1:0] cnt;   // Pacing counter for slow mode
  // Take requests and answer in order; slow mode stalls both ways
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      q.delete();
      ireq_tready  <= 1'b1;
      iresp_tvalid <= 1'b0;
      iresp_tdata  <= '0;
      cnt          <= 2'h0;
    end else begin
      cnt         <= cnt + 2'h1;
      ireq_tready <= !slow || cnt[0];
      // Beat moves only with valid and ready both high
      if (ireq_tvalid && ireq_tready &&
          ireq_tdata.kind inside {KIND_NREAD, KIND_NWRITE_R, KIND_DOORBELL}) begin
        p      = ireq_tdata;
        // Bad mode swaps the answer kind on purpose
        p.kind = ((p.kind == KIND_NREAD) ^ bad) ? KIND_RESP_DATA : KIND_RESP_NODT;
        q.push_back(p);
      end
      // Released data is scrambled so a stale value never looks valid
      if (iresp_tvalid && iresp_tready) begin
        iresp_tvalid <= 1'b0;
        iresp_tdata  <= ioxr_pkt_t'(~iresp_tdata);
      end else if (!iresp_tvalid && q.size() > 0 && (!slow || cnt == 2'h3)) begin
        iresp_tvalid <= 1'b1;
        iresp_tdata  <= q.pop_front();
      end
    end
  end
endmodule : ioxr_core_model

// File: bench/ioxr_top_asserts.sv
`timescale 1ns/10ps
// ****************************************************************
// Port checker for the I/O exerciser
// ****************************************************************
module ioxr_top_chk
  import ioxr_pkg::*;
#(
  parameter logic [4:0] ALLOWED_KINDS = 5'h1f  // Permitted request kinds
) (
  // Clock and reset
  input wire logic                clk,
  input wire logic                reset,
  // Initiator side
  input wire logic                ireq_tvalid,
  input wire logic                ireq_tready,
  input wire ioxr_pkg::ioxr_pkt_t ireq_tdata,
  input wire logic                iresp_tvalid,
  // Target side
  input wire logic                treq_tvalid,
  input wire logic                treq_tready,
  input wire ioxr_pkg::ioxr_pkt_t treq_tdata,
  input wire logic                tresp_tvalid,
  input wire logic                tresp_tready,
  input wire ioxr_pkg::ioxr_pkt_t tresp_tdata,
  // Status
  input wire logic                exercise_done,
  input wire logic                mismatch_seen
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ioxr_pkt_t req_reg;                                    // Last target request taken
  wire logic t_take = treq_tvalid && treq_tready;        // Target take
  wire logic t_scr  = treq_tdata.addr[SCRATCH_HI:SCRATCH_LO] == SCRATCH_TAG;  // Scratch hit
  // Hold the request so the answer fields can be tied to it
  always_ff @(posedge clk) begin
    if (t_take) begin
      req_reg <= treq_tdata;
    end
  end
  property p_kind_ok;
    ireq_tvalid |-> ireq_tdata.kind <= KIND_DOORBELL && ALLOWED_KINDS[ireq_tdata.kind];
  endproperty
  a_kind_ok: assert property (p_kind_ok) else $error("request kind not permitted");
  property p_ireq_hold;
    ireq_tvalid && !ireq_tready |=> ireq_tvalid && $stable(ireq_tdata);
  endproperty
  a_ireq_hold: assert property (p_ireq_hold) else $error("request dropped or changed");
  property p_ireq_gap;
    ireq_tvalid && ireq_tready |=> !ireq_tvalid;
  endproperty
  a_ireq_gap: assert property (p_ireq_gap) else $error("no load cycle after request");
  property p_tresp_hold;
    tresp_tvalid && !tresp_tready |=> tresp_tvalid && $stable(tresp_tdata);
  endproperty
  a_tresp_hold: assert property (p_tresp_hold) else $error("answer dropped or changed");
  property p_t_busy;
    t_take && treq_tdata.kind inside {KIND_NREAD, KIND_NWRITE_R, KIND_DOORBELL} |=> !treq_tready;
  endproperty
  a_t_busy: assert property (p_t_busy) else $error("second request taken early");
  property p_no_answer;
    t_take && treq_tdata.kind inside {KIND_NWRITE, KIND_SWRITE} |=> !tresp_tvalid;
  endproperty
  a_no_answer: assert property (p_no_answer) else $error("write answered");
  property p_mem_read;
    t_take && treq_tdata.kind == KIND_NREAD && t_scr |=> !tresp_tvalid ##1 tresp_tvalid;
  endproperty
  a_mem_read: assert property (p_mem_read) else $error("scratch read latency");
  property p_answer;
    t_take && (treq_tdata.kind inside {KIND_NWRITE_R, KIND_DOORBELL} ||
               treq_tdata.kind == KIND_NREAD && !t_scr) |=> tresp_tvalid;
  endproperty
  a_answer: assert property (p_answer) else $error("answer missing");
  property p_fields;
    tresp_tvalid |-> tresp_tdata.tid == req_reg.tid && tresp_tdata.addr == req_reg.addr &&
      tresp_tdata.prio == 2'(req_reg.prio + PRIO_STEP) &&
      tresp_tdata.kind == (req_reg.kind == KIND_NREAD ? KIND_RESP_DATA : KIND_RESP_NODT);
  endproperty
  a_fields: assert property (p_fields) else $error("answer fields wrong");
  property p_mm_sticky;
    mismatch_seen |=> mismatch_seen;
  endproperty
  a_mm_sticky: assert property (p_mm_sticky) else $error("mismatch flag cleared");
  property p_mm_cause;
    $rose(mismatch_seen) |-> $past(iresp_tvalid);
  endproperty
  a_mm_cause: assert property (p_mm_cause) else $error("mismatch without response");
  c_mem_read: cover property (t_take && treq_tdata.kind == KIND_NREAD && t_scr);
  c_done: cover property ($rose(exercise_done));
  c_mismatch: cover property ($rose(mismatch_seen));
endmodule : ioxr_top_chk
bind ioxr_top ioxr_top_chk #(.ALLOWED_KINDS(ALLOWED_KINDS)) u_chk (.clk(clk), .reset(reset),
  .ireq_tvalid(ireq_tvalid), .ireq_tready(ireq_tready), .ireq_tdata(ireq_tdata),
  .iresp_tvalid(iresp_tvalid), .treq_tvalid(treq_tvalid), .treq_tready(treq_tready),
  .treq_tdata(treq_tdata), .tresp_tvalid(tresp_tvalid), .tresp_tready(tresp_tready),
  .tresp_tdata(tresp_tdata), .exercise_done(exercise_done), .mismatch_seen(mismatch_seen));

// File: bench/ioxr_top_bench.sv
`timescale 1ns/10ps
// ****************************************************************
// Self-checking bench for the I/O exerciser
// ****************************************************************
module ioxr_top_bench;
  import ioxr_pkg::*;
  logic clk = 1'b0, reset = 1'b1, slow = 1'b1, bad = 1'b0;       // Clock, reset, model modes
  logic ireq_v, ireq_r, iresp_v, iresp_r, treq_v = 1'b0, treq_r;  // Handshakes
  logic tresp_v, tresp_r = 1'b0, done, mism;                      // Answer and status
  ioxr_pkt_t ireq_d, iresp_d, treq_d = '0, tresp_d;               // Beats
  int n_fail = 0, compares = 0, cyc = 0;                          // Counters
  logic [7:0] base = 8'h00;                                       // Expected fill base
  always #20 clk = ~clk;
  ioxr_top dut (.clk(clk), .reset(reset), .ireq_tvalid(ireq_v), .ireq_tready(ireq_r),
    .ireq_tdata(ireq_d), .iresp_tvalid(iresp_v), .iresp_tready(iresp_r), .iresp_tdata(iresp_d),
    .treq_tvalid(treq_v), .treq_tready(treq_r), .treq_tdata(treq_d), .tresp_tvalid(tresp_v),
    .tresp_tready(tresp_r), .tresp_tdata(tresp_d), .usr_ireq_tvalid(1'b0), .usr_ireq_tready(),
    .usr_ireq_tdata('0), .usr_iresp_tvalid(), .usr_iresp_tready(1'b0), .usr_iresp_tdata(),
    .usr_treq_tvalid(), .usr_treq_tready(1'b0), .usr_treq_tdata(), .usr_tresp_tvalid(1'b0),
    .usr_tresp_tready(), .usr_tresp_tdata(treq_d), .exercise_done(done), .mismatch_seen(mism));
  ioxr_core_model u_core (.clk(clk), .reset(reset), .slow(slow), .bad(bad), .ireq_tvalid(ireq_v),
    .ireq_tready(ireq_r), .ireq_tdata(ireq_d), .iresp_tvalid(iresp_v), .iresp_tready(iresp_r),
    .iresp_tdata(iresp_d));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic end_of_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic cmp_pkt(input ioxr_pkt_t got, input ioxr_pkt_t exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp_pkt
  task automatic cmp_bit(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask : cmp_bit
  // Send one target request, then look for an answer with one stall
  task automatic xfer(input ioxr_kind_t k, input logic [31:0] a, input logic [63:0] d,
                      input logic [7:0] t, output ioxr_pkt_t r, output logic got);
    int n;
    n = 0;
    got = 1'b0;
    @(negedge clk);
    treq_d = '{kind: k, tid: t, prio: t[1:0], addr: a, data: d};
    treq_v = 1'b1;
    while (treq_r !== 1'b1 && n < 50) begin @(negedge clk); n++; end
    cmp_bit(treq_r, 1'b1, "request not taken");
    @(negedge clk);
    treq_v = 1'b0;
    treq_d = ioxr_pkt_t'(~treq_d);
    for (n = 0; n < 4 && !got; n++) begin
      if (tresp_v === 1'b1) begin
        got = 1'b1;
        @(negedge clk);
        r = tresp_d;
        tresp_r = 1'b1;
      end
      @(negedge clk);
      tresp_r = 1'b0;
    end
  endtask : xfer
  function automatic ioxr_pkt_t ans(input ioxr_kind_t k, input logic [31:0] a,
                                    input logic [7:0] t, input logic [63:0] d);
    ans = '{kind: (k == KIND_NREAD) ? KIND_RESP_DATA : KIND_RESP_NODT,
            tid: t, prio: 2'(t[1:0] + 2'h1), addr: a, data: d};
  endfunction : ans
  function automatic logic [63:0] pat(input logic [7:0] b);
    for (int i = 0; i < 8; i++) pat[8*i +: 8] = b + 8'(i);
  endfunction : pat
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_scratch;
    ioxr_pkt_t r;
    logic g;
    xfer(KIND_NWRITE, 32'h0012_0010, 64'h0123_4567_89ab_cdef, 8'h23, r, g);
    cmp_bit(g, 1'b0, "scratch write answered");
    xfer(KIND_NREAD, 32'h0012_0010, 64'h0, 8'h43, r, g);
    cmp_pkt(r, ans(KIND_NREAD, 32'h0012_0010, 8'h43, 64'h0123_4567_89ab_cdef), "scratch read");
  endtask : t_scratch
  task automatic t_silent;
    ioxr_pkt_t r;
    logic g;
    xfer(KIND_SWRITE, 32'h0012_0018, 64'h5, 8'h05, r, g);
    cmp_bit(g, 1'b0, "scratch swrite answered");
    xfer(KIND_SWRITE, 32'h0044_0000, 64'h6, 8'h06, r, g);
    cmp_bit(g, 1'b0, "swrite answered");
    xfer(KIND_NWRITE, 32'h0044_0008, 64'h7, 8'h07, r, g);
    cmp_bit(g, 1'b0, "plain write answered");
  endtask : t_silent
  task automatic t_pattern;
    ioxr_pkt_t r;
    logic g;
    xfer(KIND_NREAD, 32'h0033_0040, 64'h0, 8'h12, r, g);
    cmp_pkt(r, ans(KIND_NREAD, 32'h0033_0040, 8'h12, pat(base)), "fill read");
    base++;
    xfer(KIND_DOORBELL, 32'h0000_0000, 64'h9, 8'h31, r, g);
    cmp_pkt(r, ans(KIND_DOORBELL, 32'h0, 8'h31, pat(base)), "doorbell");
    base++;
    xfer(KIND_NWRITE_R, 32'h0055_0000, 64'h8, 8'h22, r, g);
    cmp_pkt(r, ans(KIND_NWRITE_R, 32'h0055_0000, 8'h22, pat(base)), "write answer");
    base++;
    xfer(KIND_NREAD, 32'h0033_0048, 64'h0, 8'h40, r, g);
    cmp_pkt(r, ans(KIND_NREAD, 32'h0033_0048, 8'h40, pat(base)), "fill advance");
  endtask : t_pattern
  task automatic t_auto;
    int n;
    for (n = 0; n < 3000 && done !== 1'b1; n++) @(negedge clk);
    cmp_bit(done, 1'b1, "script not finished");
    cmp_bit(mism, 1'b0, "false mismatch");
  endtask : t_auto
  // Second run with swapped answer kinds must be flagged
  task automatic t_bad;
    int n;
    @(negedge clk);
    reset = 1'b1;
    bad = 1'b1;
    slow = 1'b0;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    for (n = 0; n < 3000 && mism !== 1'b1; n++) @(negedge clk);
    cmp_bit(mism, 1'b1, "mismatch not flagged");
  endtask : t_bad
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    reset = 1'b0;
    t_scratch();
    t_silent();
    t_pattern();
    t_auto();
    t_bad();
    end_of_test();
  end
endmodule : ioxr_top_bench
